// ### logic/fhp_buf_if.sv
// Carrier between the controller and its page buffer
`timescale 1ns/1ps
`default_nettype none
interface fhp_buf_if;
  import fhp_pkg::*;
  logic             ld_en;
  logic [IDX_W-1:0] ld_idx;
  logic [7:0]       ld_data;
  logic             clr;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0]       rd_data;
  logic             rd_loaded;
  modport ctrl (output ld_en, ld_idx, ld_data, clr, rd_idx, input rd_data, rd_loaded);
  modport buff (input ld_en, ld_idx, ld_data, clr, rd_idx, output rd_data, rd_loaded);
endinterface
`default_nettype wire

// ### logic/fhp_ctrl.sv
// Half-page flash programming controller: mapping, launch key, sequencer
`timescale 1ns/1ps
`default_nettype none
module fhp_ctrl #(
  parameter int ERASE_CYC = fhp_pkg::ERASE_CYC_DEF,
  parameter int PROG_CYC  = fhp_pkg::PROG_CYC_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Special register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Core status
  input  wire logic        instr_retire,
  input  wire logic        exec_internal,
  input  wire logic        brownout,
  output logic             core_stall,
  // Core external data writes
  input  wire logic        xd_wr,
  input  wire logic [15:0] xd_addr,
  input  wire logic [7:0]  xd_wdata,
  output logic             dmem_wr,
  output logic             dmem_ext,
  output logic [15:0]      dmem_addr,
  output logic [7:0]       dmem_wdata,
  // Core code reads
  input  wire logic        cr_rd,
  input  wire logic [15:0] cr_addr,
  output logic [7:0]       code_rdata,
  output logic             code_rvalid,
  // Flash array port
  output logic             arr_rd,
  output logic             arr_wr,
  output logic             arr_erase,
  output logic [1:0]       arr_space,
  output logic [15:0]      arr_addr,
  output logic [7:0]       arr_wdata,
  input  wire logic [7:0]  arr_rdata
);
  import fhp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ERASE, S_ERASE_WAIT, S_PROG, S_PROG_WAIT
  } fhp_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  fhp_state_t       state_r, state_nxt;
  logic [3:0]       key_r;
  logic             map_r;
  logic [1:0]       space_r;
  logic             busy_r;
  logic [7:0]       nvm_r;
  logic             xram_r;
  logic             armed_r;
  logic [15:6]      last_half_r;
  logic [15:6]      tgt_half_r;
  logic [1:0]       tgt_space_r;
  logic [IDX_W-1:0] idx_r;
  logic [7:0]       reg_rdata_r;
  logic             core_stall_r;
  logic             dmem_wr_r;
  logic             dmem_ext_r;
  logic [15:0]      dmem_addr_r;
  logic [7:0]       dmem_wdata_r;
  logic [7:0]       code_rdata_r;
  logic             code_rvalid_r;
  logic             arr_rd_r;
  logic             arr_wr_r;
  logic             arr_erase_r;
  logic [1:0]       arr_space_r;
  logic [15:0]      arr_addr_r;
  logic [7:0]       arr_wdata_r;

  fhp_buf_if buf_bus ();

  fhp_page_buf u_buf (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (buf_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire ctl_wr    = reg_wr && reg_addr == FLASH_CONTROL_ADDR;
  wire nvm_wr    = reg_wr && reg_addr == NVM_CONTROL_ADDR;
  wire aux_wr    = reg_wr && reg_addr == AUX_CONTROL_ADDR;
  wire [3:0] key_in = reg_wdata[KEY_MSB:KEY_LSB];
  wire key_first = ctl_wr && key_in == KEY_FIRST;
  // Second half of the key only counts straight after the first
  wire key_done  = ctl_wr && key_in == KEY_SECOND && armed_r;
  wire launch    = key_done && !busy_r && space_r != SPC_RSVD;
  wire auto_erase = nvm_r[AUTO_ERASE_BIT];
  wire [7:0] ctl_rd  = {key_r, map_r, space_r, busy_r};
  wire [7:0] rd_mux  = (reg_addr == FLASH_CONTROL_ADDR) ? ctl_rd :
                       (reg_addr == NVM_CONTROL_ADDR)   ? nvm_r :
                       (reg_addr == AUX_CONTROL_ADDR)   ? {6'h00, xram_r, 1'b0} :
                       8'h00;

  // Flash control register; busy bit is hardware only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_r   <= 4'h0;
      map_r   <= 1'b0;
      space_r <= 2'b00;
    end else if (ctl_wr) begin
      key_r   <= key_in;
      map_r   <= reg_wdata[MAP_BIT];
      space_r <= reg_wdata[SPC_MSB:SPC_LSB];
    end
  end

  // Nvm and auxiliary control; error bit set by hardware or by writing one, cleared by writing zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nvm_r  <= NVM_RESET;
      xram_r <= 1'b0;
    end else begin
      if (nvm_wr) begin
        nvm_r <= reg_wdata & NVM_WMASK;
      end
      if (brownout && busy_r) begin
        nvm_r[ERR_BIT] <= 1'b1;
      end else if (nvm_wr) begin
        nvm_r[ERR_BIT] <= reg_wdata[ERR_BIT];
      end
      if (aux_wr) begin
        xram_r <= reg_wdata[XRAM_BIT];
      end
    end
  end

  // Key arming; any other instruction in between disarms
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b0;
    end else if (ctl_wr) begin
      armed_r <= key_first;
    end else if (instr_retire) begin
      armed_r <= 1'b0;
    end
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_mux;
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data write routing
  // Buffer mapping wins over the external RAM select bit
  wire to_buf  = xd_wr && map_r;
  wire to_dmem = xd_wr && !map_r;

  assign buf_bus.ld_en   = to_buf && !busy_r;
  assign buf_bus.ld_idx  = xd_addr[IDX_W-1:0];
  assign buf_bus.ld_data = xd_wdata;

  // Forward ordinary writes; remember last page and half loaded
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dmem_wr_r    <= 1'b0;
      dmem_ext_r   <= 1'b0;
      dmem_addr_r  <= 16'h0000;
      dmem_wdata_r <= 8'h00;
      last_half_r  <= '0;
    end else begin
      dmem_wr_r <= to_dmem;
      if (to_dmem) begin
        dmem_ext_r   <= xram_r;
        dmem_addr_r  <= xd_addr;
        dmem_wdata_r <= xd_wdata;
      end
      if (buf_bus.ld_en) begin
        last_half_r <= xd_addr[15:6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic tmr_start;
  logic tmr_done;
  logic [CNT_W-1:0] tmr_cyc;
  wire  abort     = brownout && busy_r;
  wire  last_idx  = idx_r == IDX_W'(BUF_BYTES - 1);
  wire [15:0] tgt_addr = {tgt_half_r, idx_r};
  // Vendor signature and security regions never take program writes; erase is not blocked there
  wire  ro_hit    = (tgt_space_r == SPC_SIG  && tgt_addr >= SIG_RO_BASE) ||
                    (tgt_space_r == SPC_FUSE && tgt_addr >= FUSE_RO_BASE);
  wire  prog_byte = state_r == S_PROG && buf_bus.rd_loaded && !ro_hit;

  assign buf_bus.rd_idx = idx_r;
  assign buf_bus.clr    = (state_r == S_PROG_WAIT && tmr_done) || abort;

  fhp_op_timer u_tmr (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (tmr_start),
    .cycles  (tmr_cyc),
    .abort   (abort),
    .done    (tmr_done)
  );

  // Next state and timer start
  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_cyc   = CNT_W'(PROG_CYC);
    case (state_r)
      S_IDLE: begin
        if (launch && auto_erase) begin
          state_nxt = S_ERASE;
        end else if (launch) begin
          state_nxt = S_PROG;
        end
      end
      S_ERASE: begin
        tmr_start = 1'b1;
        tmr_cyc   = CNT_W'(ERASE_CYC);
        state_nxt = S_ERASE_WAIT;
      end
      S_ERASE_WAIT: begin
        if (tmr_done) begin
          state_nxt = S_PROG;
        end
      end
      S_PROG: begin
        if (last_idx) begin
          tmr_start = 1'b1;
          state_nxt = S_PROG_WAIT;
        end
      end
      S_PROG_WAIT: begin
        if (tmr_done) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    if (abort) begin
      state_nxt = S_IDLE;
    end
  end

  // State, busy flag, stall, latched target
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r      <= S_IDLE;
      busy_r       <= 1'b0;
      core_stall_r <= 1'b0;
      idx_r        <= '0;
      tgt_half_r   <= '0;
      tgt_space_r  <= 2'b00;
    end else begin
      state_r <= state_nxt;
      busy_r  <= state_nxt != S_IDLE;
      if (launch) begin
        core_stall_r <= exec_internal;
        tgt_half_r   <= last_half_r;
        tgt_space_r  <= space_r;
      end else if (state_nxt == S_IDLE) begin
        core_stall_r <= 1'b0;
      end
      if (state_r == S_PROG) begin
        idx_r <= idx_r + IDX_W'(1);
      end else begin
        idx_r <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array port: sequencer owns it while busy, else code reads
  // The core reaches code space only through reads here; erase and program writes come from the sequencer
  wire cr_take = cr_rd && !busy_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arr_rd_r    <= 1'b0;
      arr_wr_r    <= 1'b0;
      arr_erase_r <= 1'b0;
      arr_space_r <= 2'b00;
      arr_addr_r  <= 16'h0000;
      arr_wdata_r <= 8'h00;
    end else begin
      arr_rd_r    <= cr_take;
      arr_wr_r    <= prog_byte;
      // Erase clears the whole page, both halves
      arr_erase_r <= state_r == S_ERASE;
      if (state_r == S_ERASE) begin
        arr_space_r <= tgt_space_r;
        arr_addr_r  <= {tgt_half_r[15:7], 7'h00};
      end else if (state_r == S_PROG) begin
        arr_space_r <= tgt_space_r;
        arr_addr_r  <= tgt_addr;
        arr_wdata_r <= buf_bus.rd_data;
      end else if (cr_take) begin
        arr_space_r <= space_r;
        arr_addr_r  <= cr_addr;
      end
    end
  end

  // Read data returns two cycles after the request; reserved space reads blank
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      code_rvalid_r <= 1'b0;
      code_rdata_r  <= 8'h00;
    end else begin
      code_rvalid_r <= arr_rd_r;
      if (arr_rd_r) begin
        code_rdata_r <= (arr_space_r == SPC_RSVD) ? BLANK_BYTE : arr_rdata;
      end
    end
  end

  assign reg_rdata   = reg_rdata_r;
  assign core_stall  = core_stall_r;
  assign dmem_wr     = dmem_wr_r;
  assign dmem_ext    = dmem_ext_r;
  assign dmem_addr   = dmem_addr_r;
  assign dmem_wdata  = dmem_wdata_r;
  assign code_rdata  = code_rdata_r;
  assign code_rvalid = code_rvalid_r;
  assign arr_rd      = arr_rd_r;
  assign arr_wr      = arr_wr_r;
  assign arr_erase   = arr_erase_r;
  assign arr_space   = arr_space_r;
  assign arr_addr    = arr_addr_r;
  assign arr_wdata   = arr_wdata_r;
endmodule
`default_nettype wire

// ### logic/fhp_op_timer.sv
// Down-counter that times one erase or program step
`timescale 1ns/1ps
`default_nettype none
module fhp_op_timer (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [fhp_pkg::CNT_W-1:0] cycles,
  input  wire logic             abort,
  output logic                  done
);
  import fhp_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  logic             run_r;

  // Done pulses in the cycle the count reaches one
  assign done = run_r && cnt_r == CNT_W'(1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (abort || done) begin
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= cycles;
      run_r <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// ### logic/fhp_page_buf.sv
// Write-once 64-byte page buffer with loaded flags
`timescale 1ns/1ps
`default_nettype none
module fhp_page_buf (
  input  wire logic clk_sys,
  input  wire logic rst,
  fhp_buf_if.buff   bus
);
  import fhp_pkg::*;
  logic [7:0]           mem_r [BUF_BYTES];
  logic [BUF_BYTES-1:0] loaded_r;

  // Data bytes need no reset; the loaded flags say what is valid
  always_ff @(posedge clk_sys) begin
    if (bus.ld_en && !loaded_r[bus.ld_idx]) begin
      mem_r[bus.ld_idx] <= bus.ld_data;
    end
  end

  // One flag per byte, wiped by the clear pulse
  generate
    for (genvar i = 0; i < BUF_BYTES; i++) begin : g_flag
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          loaded_r[i] <= 1'b0;
        end else if (bus.clr) begin
          loaded_r[i] <= 1'b0;
        end else if (bus.ld_en && bus.ld_idx == IDX_W'(i)) begin
          loaded_r[i] <= 1'b1;
        end
      end
    end
  endgenerate

  assign bus.rd_loaded = loaded_r[bus.rd_idx];
  assign bus.rd_data   = loaded_r[bus.rd_idx] ? mem_r[bus.rd_idx] : BLANK_BYTE;
endmodule
`default_nettype wire

// ### logic/fhp_pkg.sv
// Constants and types shared by the half-page flash programming control block
package fhp_pkg;
  // Special register addresses
  localparam logic [7:0] FLASH_CONTROL_ADDR = 8'hD1;
  localparam logic [7:0] NVM_CONTROL_ADDR   = 8'hD2;
  localparam logic [7:0] AUX_CONTROL_ADDR   = 8'h8E;
  // Flash control fields
  localparam int KEY_MSB  = 7;
  localparam int KEY_LSB  = 4;
  localparam int MAP_BIT  = 3;
  localparam int SPC_MSB  = 2;
  localparam int SPC_LSB  = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [3:0] KEY_FIRST  = 4'h5;
  localparam logic [3:0] KEY_SECOND = 4'hA;
  // Nvm control fields
  localparam int AUTO_ERASE_BIT = 6;
  localparam int ERR_BIT        = 2;
  localparam logic [7:0] NVM_RESET = 8'h80;
  localparam logic [7:0] NVM_WMASK = 8'hFB;
  // Auxiliary control field
  localparam int XRAM_BIT = 1;
  // Space encodings
  typedef enum logic [1:0] {
    SPC_CODE = 2'b00,
    SPC_SIG  = 2'b01,
    SPC_FUSE = 2'b10,
    SPC_RSVD = 2'b11
  } fhp_space_t;
  // Read-only region starts
  localparam logic [15:0] SIG_RO_BASE  = 16'h0200;
  localparam logic [15:0] FUSE_RO_BASE = 16'h0080;
  // Page buffer geometry
  localparam int BUF_BYTES = 64;
  localparam int IDX_W     = 6;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  // Default operation lengths in cycles
  localparam int ERASE_CYC_DEF = 1000;
  localparam int PROG_CYC_DEF  = 1000;
  localparam int CNT_W         = 16;
endpackage

// ### sim/fhp_array_model.sv
// Behavioural flash array behind the controller's array port
`timescale 1ns/1ps
`default_nettype none
module fhp_array_model
  import fhp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arr_rd,
  input  wire logic        arr_wr,
  input  wire logic        arr_erase,
  input  wire logic [1:0]  arr_space,
  input  wire logic [15:0] arr_addr,
  input  wire logic [7:0]  arr_wdata,
  output logic      [7:0]  arr_rdata
);
  logic [7:0] mem [int];
  logic       tgl_r = 1'b0;
  function automatic logic [7:0] peek(input int k);
    return mem.exists(k) ? mem[k] : BLANK_BYTE;
  endfunction
  // Data only while read; a changing pattern otherwise, so stale bytes never pass
  assign arr_rdata = arr_rd ? peek(int'({arr_space, arr_addr})) : (8'hA5 ^ {8{tgl_r}});
  // Erase blanks the whole page; a write can only clear bits
  always @(posedge clk_sys) begin
    tgl_r <= ~tgl_r;
    if (arr_erase) begin
      for (int i = 0; i < 128; i++) begin
        mem[int'({arr_space, arr_addr[15:7], 7'(i)})] = BLANK_BYTE;
      end
    end
    if (arr_wr) begin
      mem[int'({arr_space, arr_addr})] = peek(int'({arr_space, arr_addr})) & arr_wdata;
    end
  end
endmodule
`default_nettype wire

// ### sim/fhp_ctrl_monitor.sv
// Assertion checker on the controller's top ports
`timescale 1ns/1ps
`default_nettype none
module fhp_ctrl_monitor
  import fhp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        exec_internal,
  input wire logic        brownout,
  input wire logic        core_stall,
  input wire logic        xd_wr,
  input wire logic [15:0] xd_addr,
  input wire logic        dmem_wr,
  input wire logic [15:0] dmem_addr,
  input wire logic        cr_rd,
  input wire logic        code_rvalid,
  input wire logic        arr_wr,
  input wire logic        arr_erase,
  input wire logic [1:0]  arr_space,
  input wire logic [15:0] arr_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Key writes decoded from the register port
  wire logic k5 = reg_wr && reg_addr == FLASH_CONTROL_ADDR && reg_wdata[7:4] == KEY_FIRST;
  wire logic ka = reg_wr && reg_addr == FLASH_CONTROL_ADDR && reg_wdata[7:4] == KEY_SECOND;
  wire logic ro = (arr_space == SPC_SIG && arr_addr >= SIG_RO_BASE)
               || (arr_space == SPC_FUSE && arr_addr >= FUSE_RO_BASE);
  ////////////////////////////////////////
  property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_launch; k5 && !core_stall ##1 ka && reg_wdata[2:1] != 2'b11 && exec_internal
    |=> core_stall; endproperty
  a_launch: assert property (p_launch) else $error("launch did not stall");
  property p_rose_cause; $rose(core_stall) |-> $past(ka) && $past(k5, 2)
    && $past(reg_wdata[2:1]) != 2'b11; endproperty
  a_rose_cause: assert property (p_rose_cause) else $error("stall without key");
  property p_stall_max; $rose(core_stall) |-> ##[1:200] !core_stall; endproperty
  a_stall_max: assert property (p_stall_max) else $error("operation never ends");
  property p_stall_min; $rose(core_stall) ##0 !brownout [*8] |-> core_stall; endproperty
  a_stall_min: assert property (p_stall_min) else $error("operation too short");
  property p_brownout; brownout && core_stall |-> ##[1:2] !core_stall; endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out ignored");
  property p_fwd; xd_wr ##1 dmem_wr |-> dmem_addr == $past(xd_addr); endproperty
  a_fwd: assert property (p_fwd) else $error("data write address lost");
  property p_erase_page; arr_erase |-> arr_addr[6:0] == 7'h00; endproperty
  a_erase_page: assert property (p_erase_page) else $error("erase not page aligned");
  property p_ro_skip; arr_wr |-> !ro; endproperty
  a_ro_skip: assert property (p_ro_skip) else $error("read-only place written");
  property p_code_rd; cr_rd && !core_stall |-> ##2 code_rvalid; endproperty
  a_code_rd: assert property (p_code_rd) else $error("code read unanswered");
  // Main scenarios reached
  c_launch: cover property (ka ##1 core_stall);
  c_brown: cover property (brownout && core_stall);
  c_erase: cover property (arr_erase);
  c_fuse: cover property (arr_wr && arr_space == SPC_FUSE);
endmodule
`default_nettype wire

// ### sim/fhp_ctrl_tb.sv
// Self-checking bench for the half-page flash programming controller
`timescale 1ns/1ps
`default_nettype none
module fhp_ctrl_tb;
  import fhp_pkg::*;
  logic        clk_sys, rst, reg_wr, reg_rd, instr_retire, exec_internal, brownout;
  logic        core_stall, xd_wr, dmem_wr, dmem_ext, cr_rd, code_rvalid;
  logic        arr_rd, arr_wr, arr_erase;
  logic [1:0]  arr_space;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, xd_wdata, dmem_wdata;
  logic [7:0]  code_rdata, arr_wdata, arr_rdata, v;
  logic [15:0] xd_addr, dmem_addr, cr_addr, arr_addr;
  logic [31:0] seed;
  logic [7:0]  mm [int];
  logic [7:0]  bv [64];
  bit          ld [64];
  int          mismatches, checked;
  fhp_ctrl #(.ERASE_CYC(4), .PROG_CYC(4)) uut (.*);
  fhp_array_model arr (.clk_sys(clk_sys), .arr_rd(arr_rd), .arr_wr(arr_wr),
    .arr_erase(arr_erase), .arr_space(arr_space), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_at(input int k);
    return mm.exists(k) ? mm[k] : 8'hFF;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One register cycle; read data lands in v
  task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, a, 8'h00);
    chk({8'h00, v & m}, {8'h00, e});
  endtask
  // Key pair back to back; a retired instruction between them should disarm
  task automatic key(input logic [1:0] sp, input bit gap);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= FLASH_CONTROL_ADDR;
    reg_wdata <= {KEY_FIRST, 1'b0, sp, 1'b0};
    if (gap) begin
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      instr_retire <= 1'b1;
    end
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    instr_retire <= 1'b0;
    reg_wdata <= {KEY_SECOND, 1'b0, sp, 1'b0};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d, input bit fwd);
    @(posedge clk_sys);
    xd_wr <= 1'b1;
    xd_addr <= a;
    xd_wdata <= d;
    @(posedge clk_sys);
    xd_wr <= 1'b0;
    #1 chk({15'h0000, dmem_wr}, {15'h0000, fwd});
  endtask
  task automatic cr(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    cr_rd <= 1'b1;
    cr_addr <= a;
    @(posedge clk_sys);
    cr_rd <= 1'b0;
    @(posedge clk_sys);
    #1 chk({7'h00, code_rvalid, code_rdata}, {7'h00, 1'b1, e});
  endtask
  // Load, launch, wait, then read the whole page back against the model
  task automatic prog(input logic [1:0] sp, input logic [15:0] pg, input bit ae,
                      input bit inter, input int n);
    logic [15:0] a;
    bit          ro;
    bus(1'b1, NVM_CONTROL_ADDR, {1'b1, ae, 6'h00});
    bus(1'b1, FLASH_CONTROL_ADDR, 8'h08);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(lfsr(seed));
      a = {pg[15:6] ^ ((i == 0) ? 10'h004 : 10'h000), seed[5:0]};
      xw(a, seed[15:8], 1'b0);
      if (!ld[a[5:0]]) begin
        ld[a[5:0]] = 1'b1;
        bv[a[5:0]] = seed[15:8];
      end
    end
    bus(1'b1, FLASH_CONTROL_ADDR, 8'h00);
    @(posedge clk_sys);
    exec_internal <= inter;
    key(sp, 1'b0);
    // Busy must be seen high first, so the poll below really waits
    bus(1'b0, FLASH_CONTROL_ADDR, 8'h00);
    chk({15'h0000, v[BUSY_BIT]}, 16'h0001);
    chk({15'h0000, core_stall}, {15'h0000, inter});
    for (int i = 0; i < 128 && ae; i++) begin
      mm[int'({sp, pg[15:7], 7'(i)})] = 8'hFF;
    end
    for (int i = 0; i < 64; i++) begin
      a = {pg[15:6], 6'(i)};
      ro = (sp == SPC_SIG && a >= SIG_RO_BASE) || (sp == SPC_FUSE && a >= FUSE_RO_BASE);
      if (ld[i] && !ro) begin
        mm[int'({sp, a})] = exp_at(int'({sp, a})) & bv[i];
      end
      ld[i] = 1'b0;
    end
    for (int i = 0; i < 300 && v[BUSY_BIT] !== 1'b0; i++) begin
      bus(1'b0, FLASH_CONTROL_ADDR, 8'h00);
    end
    chk({15'h0000, v[BUSY_BIT]}, 16'h0000);
    bus(1'b1, FLASH_CONTROL_ADDR, {5'h00, sp, 1'b0});
    for (int i = 0; i < 128; i++) begin
      cr({pg[15:7], 7'(i)}, exp_at(int'({sp, pg[15:7], 7'(i)})));
    end
    bus(1'b1, FLASH_CONTROL_ADDR, 8'h00);
  endtask
  // Free-running core clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, instr_retire, exec_internal, brownout, xd_wr, cr_rd} = '0;
    {reg_addr, reg_wdata, xd_addr, xd_wdata, cr_addr} = '0;
    mismatches = 0;
    checked = 0;
    v = 8'h00;
    seed = 32'h83DB;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(FLASH_CONTROL_ADDR, 8'h00, 8'hFF);
    rchk(NVM_CONTROL_ADDR, NVM_RESET, 8'hFF);
    rchk(8'h55, 8'h00, 8'hFF);
    bus(1'b1, FLASH_CONTROL_ADDR, 8'h09);
    rchk(FLASH_CONTROL_ADDR, 8'h08, 8'hFF);
    bus(1'b1, FLASH_CONTROL_ADDR, 8'h00);
    bus(1'b1, AUX_CONTROL_ADDR, 8'h02);
    xw(16'h1234, 8'h5A, 1'b1);
    chk({15'h0000, dmem_ext}, 16'h0001);
    chk(dmem_addr, 16'h1234);
    chk({8'h00, dmem_wdata}, 16'h005A);
    prog(SPC_CODE, 16'h1280, 1'b0, 1'b1, 40);
    prog(SPC_CODE, 16'h12C0, 1'b1, 1'b0, 20);
    prog(SPC_CODE, 16'h12C0, 1'b0, 1'b1, 30);
    prog(SPC_SIG, 16'h01C0, 1'b0, 1'b0, 20);
    prog(SPC_SIG, 16'h0200, 1'b0, 1'b1, 10);
    prog(SPC_FUSE, 16'h0040, 1'b0, 1'b1, 10);
    prog(SPC_FUSE, 16'h0080, 1'b0, 1'b0, 10);
    bus(1'b1, FLASH_CONTROL_ADDR, 8'h50);
    rchk(FLASH_CONTROL_ADDR, 8'h00, 8'h01);
    key(SPC_CODE, 1'b1);
    rchk(FLASH_CONTROL_ADDR, 8'h00, 8'h01);
    key(SPC_RSVD, 1'b0);
    rchk(FLASH_CONTROL_ADDR, 8'h00, 8'h01);
    @(posedge clk_sys);
    exec_internal <= 1'b1;
    key(SPC_CODE, 1'b0);
    repeat (3) @(posedge clk_sys);
    brownout <= 1'b1;
    @(posedge clk_sys);
    brownout <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rchk(FLASH_CONTROL_ADDR, 8'h00, 8'h01);
    rchk(NVM_CONTROL_ADDR, 8'h84, 8'hFF);
    bus(1'b1, NVM_CONTROL_ADDR, NVM_RESET);
    rchk(NVM_CONTROL_ADDR, NVM_RESET, 8'hFF);
    bus(1'b1, FLASH_CONTROL_ADDR, 8'h06);
    cr(16'h0010, 8'hFF);
    close_out();
  end
endmodule
bind fhp_ctrl fhp_ctrl_monitor mon (.*);
`default_nettype wire
